// file: dafmt_regs.svh
/*
 Register offsets, field positions, reset values, codes and timing counts
 of the dual converter output formatter. Assumes a 100 MHz bus clock.
*/
`ifndef DAFMT_REGS_SVH
`define DAFMT_REGS_SVH

`define DAFMT_ADDR_W 4
`define DAFMT_CTRL_OFS 4'h0
`define DAFMT_STAT_OFS 4'h4

`define DAFMT_CTRL_W 7
`define DAFMT_CTRL_RST 7'h00

`define DAFMT_STAT_LOWPWR 0
`define DAFMT_STAT_LIVE_LSB 1
`define DAFMT_STAT_PD_LSB 3
`define DAFMT_STAT_FPIN 5

`define DAFMT_MODE_NORMAL 4'h0
`define DAFMT_MODE_BUF_B 4'h9
`define DAFMT_MODE_BUF_A 4'ha
`define DAFMT_MODE_BUF_AB 4'hb
`define DAFMT_MODE_GPD 4'hc
`define DAFMT_MODE_STBY_B 4'hd
`define DAFMT_MODE_STBY_A 4'he
`define DAFMT_MODE_MUX 4'hf

`define DAFMT_POS_OB 11'h7ff
`define DAFMT_POS_2C 11'h3ff
`define DAFMT_NEG_OB 11'h000
`define DAFMT_NEG_2C 11'h400

`define DAFMT_CLK_NS 10
`define DAFMT_STBY_WAKE_NS 1000
`define DAFMT_BUF_WAKE_NS 100
`define DAFMT_GPD_WAKE_NS 20000
`define DAFMT_LOWRATE_NS 1000
`define DAFMT_STBY_WAKE_CYC ((`DAFMT_STBY_WAKE_NS + `DAFMT_CLK_NS - 1) / `DAFMT_CLK_NS)
`define DAFMT_BUF_WAKE_CYC ((`DAFMT_BUF_WAKE_NS + `DAFMT_CLK_NS - 1) / `DAFMT_CLK_NS)
`define DAFMT_GPD_WAKE_CYC ((`DAFMT_GPD_WAKE_NS + `DAFMT_CLK_NS - 1) / `DAFMT_CLK_NS)
`define DAFMT_LOWRATE_CYC (`DAFMT_LOWRATE_NS / `DAFMT_CLK_NS)

`endif

// file: dafmt_pkg.sv
/*
 Types of the dual converter output formatter.
 Assumes nothing beyond a SystemVerilog tool.
*/
package dafmt_pkg;

   typedef enum logic [1:0] {
      DAFMT_CH_ON,
      DAFMT_CH_BUF_OFF,
      DAFMT_CH_STBY,
      DAFMT_CH_GPD
   } dafmt_cause_e;

   typedef struct packed {
      logic pin_cfg;
      logic twos_sel;
      logic ddr_sel;
      logic [3:0] pwr_mode;
   } dafmt_ctrl_s;

   typedef struct packed {
      logic [10:0] code;
      logic ovr_pos;
      logic ovr_neg;
   } dafmt_sample_s;

   typedef struct packed {
      logic [5:0] ddr_lane;
      logic ddr_output_clock_pos;
      logic [10:0] par_data;
      logic parallel_output_clock;
      logic oe;
   } dafmt_pins_s;

endpackage

// file: dafmt_top.sv
/*
 Output side of a dual 11-bit sampling converter: code format, overdrive
 clamps, DDR or parallel pin interface, standby, buffer disable and the
 automatic low-power state. Assumes an Avalon-MM master on clock_i and a
 link clock at twice the sample rate; converter words arrive on it.
*/
// Function
// - Standby powers down one converter, references stay
// - Disabled buffer tri-states pins, wakes about 100ns
// - Slow sampling clock forces low-power state
// - Each channel: 11-bit word plus aligned clock
// - DDR or parallel chosen by bit or pin
// - DDR puts two bits per lane per period
// - Even bits at falling, odd at rising edge
// - Parallel: one pin per bit, once per cycle
// - Twos complement or offset binary, bit or pin
// - Positive overdrive clamps to full-scale positive
// - Negative overdrive clamps to full-scale negative
// - Four-bit power field decoded into channel modes
`timescale 1ns/10ps
`include "dafmt_regs.svh"

module dafmt_top (
   // Clocks and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic smp_clk_i,
   // Avalon-MM slave
   input wire logic [`DAFMT_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Converter core, link domain
   input wire dafmt_pkg::dafmt_sample_s samp_a_i,
   input wire dafmt_pkg::dafmt_sample_s samp_b_i,
   // Strap pin
   input wire logic format_select_pin_i,
   // Power control
   output logic [1:0] chan_pd_o,
   output logic ref_pd_o,
   output logic low_power_o,
   // Output pins
   output dafmt_pkg::dafmt_pins_s pins_a_o,
   output dafmt_pkg::dafmt_pins_s pins_b_o
);

   localparam logic [11:0] STBY_CYC = 12'(`DAFMT_STBY_WAKE_CYC);
   localparam logic [11:0] BUF_CYC = 12'(`DAFMT_BUF_WAKE_CYC);
   localparam logic [11:0] GPD_CYC = 12'(`DAFMT_GPD_WAKE_CYC);
   localparam logic [7:0] LOWRATE_CYC = 8'(`DAFMT_LOWRATE_CYC);

   dafmt_pkg::dafmt_ctrl_s ctrl_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [1:0] fpin_s_reg;
   logic [2:0] st_s_reg;
   logic [7:0] idle_cnt_reg;
   logic low_pwr_reg;
   logic [11:0] wake_cnt_reg [2];
   logic [1:0] live_reg;
   logic [1:0] chan_pd_reg;
   logic ref_pd_reg;
   logic ddr_eff;
   logic twos_eff;
   logic mux_eff;
   logic smp_edge;
   dafmt_pkg::dafmt_cause_e cause [2];
   logic [1:0] off;
   logic lk_tgl_reg;

   // Bus domain

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fpin_s_reg <= 2'h0;
      end else begin
         fpin_s_reg <= {fpin_s_reg[0], format_select_pin_i};
      end
   end

   // format source select
   // The one strap sets both choices in pin mode, high meaning DDR and twos.
   assign ddr_eff = ctrl_reg.pin_cfg ? fpin_s_reg[1] : ctrl_reg.ddr_sel;
   assign twos_eff = ctrl_reg.pin_cfg ? fpin_s_reg[1] : ctrl_reg.twos_sel;

   // Answer one cycle after the request is seen; write lands on that edge
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0;
         ctrl_reg <= `DAFMT_CTRL_RST;
      end else begin
         if ((avs_read_i || avs_write_i) && wait_reg) begin
            wait_reg <= 1'b0;
            if (avs_address_i == `DAFMT_CTRL_OFS) begin
               rdata_reg <= {25'h0, ctrl_reg};
            end else if (avs_address_i == `DAFMT_STAT_OFS) begin
               rdata_reg <= {26'h0, fpin_s_reg[1], chan_pd_reg, live_reg, low_pwr_reg};
            end else begin
               rdata_reg <= 32'h0;
            end
         end else begin
            wait_reg <= 1'b1;
         end
         if (avs_write_i && !wait_reg && avs_address_i == `DAFMT_CTRL_OFS) begin
            ctrl_reg <= avs_writedata_i[`DAFMT_CTRL_W-1:0];
         end
      end
   end

   assign avs_waitrequest_o = wait_reg;
   assign avs_readdata_o = rdata_reg;

   // sample clock watchdog
   // Only the second and third stages feed the edge detector.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_s_reg <= 3'h0;
         idle_cnt_reg <= 8'h0;
         low_pwr_reg <= 1'b0;
      end else begin
         st_s_reg <= {st_s_reg[1:0], lk_tgl_reg};
         if (smp_edge) begin
            idle_cnt_reg <= 8'h0;
         end else if (idle_cnt_reg != LOWRATE_CYC) begin
            idle_cnt_reg <= idle_cnt_reg + 8'h1;
         end
         low_pwr_reg <= !smp_edge && (idle_cnt_reg == LOWRATE_CYC);
      end
   end

   assign smp_edge = st_s_reg[2] ^ st_s_reg[1];

   always_comb begin
      mux_eff = 1'b0;
      cause[0] = dafmt_pkg::DAFMT_CH_ON;
      cause[1] = dafmt_pkg::DAFMT_CH_ON;
      case (ctrl_reg.pwr_mode)
         `DAFMT_MODE_BUF_B: cause[1] = dafmt_pkg::DAFMT_CH_BUF_OFF;
         `DAFMT_MODE_BUF_A: cause[0] = dafmt_pkg::DAFMT_CH_BUF_OFF;
         `DAFMT_MODE_BUF_AB: begin
            cause[0] = dafmt_pkg::DAFMT_CH_BUF_OFF;
            cause[1] = dafmt_pkg::DAFMT_CH_BUF_OFF;
         end
         `DAFMT_MODE_GPD: begin
            cause[0] = dafmt_pkg::DAFMT_CH_GPD;
            cause[1] = dafmt_pkg::DAFMT_CH_GPD;
         end
         `DAFMT_MODE_STBY_B: cause[1] = dafmt_pkg::DAFMT_CH_STBY;
         `DAFMT_MODE_STBY_A: cause[0] = dafmt_pkg::DAFMT_CH_STBY;
         `DAFMT_MODE_MUX: begin
            mux_eff = 1'b1;
            cause[1] = dafmt_pkg::DAFMT_CH_BUF_OFF;
         end
         default: mux_eff = 1'b0;
      endcase
      for (int i = 0; i < 2; i++) begin
         if (low_pwr_reg && cause[i] != dafmt_pkg::DAFMT_CH_GPD) begin
            cause[i] = dafmt_pkg::DAFMT_CH_STBY;
         end
      end
      off[0] = cause[0] != dafmt_pkg::DAFMT_CH_ON;
      off[1] = cause[1] != dafmt_pkg::DAFMT_CH_ON;
   end

   function automatic logic [11:0] wake_of(dafmt_pkg::dafmt_cause_e c);
      logic [11:0] w;
      w = BUF_CYC;
      if (c == dafmt_pkg::DAFMT_CH_GPD) begin
         w = GPD_CYC;
      end else if (c == dafmt_pkg::DAFMT_CH_STBY) begin
         w = STBY_CYC;
      end
      return w;
   endfunction

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_cnt_reg[0] <= 12'h0;
         wake_cnt_reg[1] <= 12'h0;
         live_reg <= 2'h0;
         chan_pd_reg <= 2'h0;
         ref_pd_reg <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (off[i]) begin
               wake_cnt_reg[i] <= wake_of(cause[i]);
            end else if (wake_cnt_reg[i] != 12'h0) begin
               wake_cnt_reg[i] <= wake_cnt_reg[i] - 12'h1;
            end
            live_reg[i] <= !off[i] && (wake_cnt_reg[i] == 12'h0);
            chan_pd_reg[i] <= cause[i] == dafmt_pkg::DAFMT_CH_STBY ||
                              cause[i] == dafmt_pkg::DAFMT_CH_GPD;
         end
         ref_pd_reg <= ctrl_reg.pwr_mode == `DAFMT_MODE_GPD;
      end
   end

   assign chan_pd_o = chan_pd_reg;
   assign ref_pd_o = ref_pd_reg;
   assign low_power_o = low_pwr_reg;

   // Link domain

   logic [1:0] lk_rst_reg;
   logic lk_rst_n;
   logic [4:0] lk_s1_reg;
   logic [4:0] lk_s2_reg;
   logic lk_ph_reg;
   logic lk_mux_sel_reg;
   logic [10:0] lk_word [2];
   dafmt_pkg::dafmt_pins_s pins_reg [2];

   // Release of the link reset waits for two link edges
   always_ff @(posedge smp_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lk_rst_reg <= 2'h0;
      end else begin
         lk_rst_reg <= {lk_rst_reg[0], 1'b1};
      end
   end

   assign lk_rst_n = lk_rst_reg[1];

   // Quasi-static settings, each bit synchronised on its own; a mode change
   // may show a mixed state for one link cycle.
   always_ff @(posedge smp_clk_i or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         lk_s1_reg <= 5'h0;
         lk_s2_reg <= 5'h0;
      end else begin
         lk_s1_reg <= {mux_eff, twos_eff, ddr_eff, live_reg};
         lk_s2_reg <= lk_s1_reg;
      end
   end

   // word rate is half link rate
   always_ff @(posedge smp_clk_i or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         lk_ph_reg <= 1'b0;
         lk_tgl_reg <= 1'b0;
         lk_mux_sel_reg <= 1'b0;
      end else begin
         lk_ph_reg <= !lk_ph_reg;
         if (lk_ph_reg) begin
            lk_tgl_reg <= !lk_tgl_reg;
            lk_mux_sel_reg <= lk_s2_reg[4] && !lk_mux_sel_reg;
         end
      end
   end

   function automatic logic [10:0] fmt_code(dafmt_pkg::dafmt_sample_s s, logic twos);
      logic [10:0] c;
      c = twos ? {~s.code[10], s.code[9:0]} : s.code;
      if (s.ovr_pos) begin
         c = twos ? `DAFMT_POS_2C : `DAFMT_POS_OB;
      end else if (s.ovr_neg) begin
         c = twos ? `DAFMT_NEG_2C : `DAFMT_NEG_OB;
      end
      return c;
   endfunction

   assign lk_word[0] = fmt_code(lk_mux_sel_reg ? samp_b_i : samp_a_i, lk_s2_reg[3]);
   assign lk_word[1] = fmt_code(samp_b_i, lk_s2_reg[3]);

   function automatic logic [5:0] even_bits(logic [10:0] w);
      return {w[10], w[8], w[6], w[4], w[2], w[0]};
   endfunction

   function automatic logic [5:0] odd_bits(logic [10:0] w);
      return {1'b0, w[9], w[7], w[5], w[3], w[1]};
   endfunction

   for (genvar g = 0; g < 2; g++) begin : g_chan
      logic [10:0] hold_reg;
      always_ff @(posedge smp_clk_i or negedge lk_rst_n) begin
         if (!lk_rst_n) begin
            pins_reg[g] <= '0;
            hold_reg <= 11'h0;
         end else begin
            pins_reg[g].oe <= lk_s2_reg[g];
            if (lk_ph_reg) begin
               hold_reg <= lk_word[g];
               pins_reg[g].ddr_output_clock_pos <= 1'b0;
               pins_reg[g].parallel_output_clock <= 1'b0;
               pins_reg[g].ddr_lane <= lk_s2_reg[2] ? even_bits(lk_word[g]) : 6'h0;
               pins_reg[g].par_data <= lk_s2_reg[2] ? 11'h0 : lk_word[g];
            end else begin
               pins_reg[g].ddr_output_clock_pos <= lk_s2_reg[2];
               pins_reg[g].parallel_output_clock <= !lk_s2_reg[2];
               pins_reg[g].ddr_lane <= lk_s2_reg[2] ? odd_bits(hold_reg) : 6'h0;
            end
         end
      end
   end

   assign pins_a_o = pins_reg[0];
   assign pins_b_o = pins_reg[1];

   // Checks, link domain

   a_pos_clamp_ob: assert property (@(posedge smp_clk_i) disable iff (!lk_rst_n)
      lk_ph_reg && samp_b_i.ovr_pos && !lk_s2_reg[3] && !lk_s2_reg[2]
      |=> pins_reg[1].par_data == 11'h7ff)
      else $error("positive clamp wrong in offset binary");
   a_pos_clamp_2c: assert property (@(posedge smp_clk_i) disable iff (!lk_rst_n)
      lk_ph_reg && samp_b_i.ovr_pos && lk_s2_reg[3] && !lk_s2_reg[2]
      |=> pins_reg[1].par_data == 11'h3ff)
      else $error("positive clamp wrong in twos complement");
   a_neg_clamp_ob: assert property (@(posedge smp_clk_i) disable iff (!lk_rst_n)
      lk_ph_reg && samp_b_i.ovr_neg && !samp_b_i.ovr_pos && !lk_s2_reg[3] && !lk_s2_reg[2]
      |=> pins_reg[1].par_data == 11'h000)
      else $error("negative clamp wrong in offset binary");
   a_neg_clamp_2c: assert property (@(posedge smp_clk_i) disable iff (!lk_rst_n)
      lk_ph_reg && samp_b_i.ovr_neg && !samp_b_i.ovr_pos && lk_s2_reg[3] && !lk_s2_reg[2]
      |=> pins_reg[1].par_data == 11'h400)
      else $error("negative clamp wrong in twos complement");
   a_ddr_even_fall: assert property (@(posedge smp_clk_i) disable iff (!lk_rst_n)
      lk_ph_reg && lk_s2_reg[2] ##1 1'b1
      |-> !pins_reg[0].ddr_output_clock_pos && pins_reg[0].ddr_lane == even_bits(g_chan[0].hold_reg))
      else $error("even bits not on falling half");
   a_ddr_odd_rise: assert property (@(posedge smp_clk_i) disable iff (!lk_rst_n)
      !lk_ph_reg && lk_s2_reg[2] && $stable(lk_s2_reg[2])
      |=> pins_reg[0].ddr_output_clock_pos && pins_reg[0].ddr_lane == odd_bits(g_chan[0].hold_reg))
      else $error("odd bits not on rising half");
   a_par_stable: assert property (@(posedge smp_clk_i) disable iff (!lk_rst_n)
      $rose(pins_reg[0].parallel_output_clock) |-> $stable(pins_reg[0].par_data))
      else $error("parallel data moved at rising clock");
   a_unused_idle: assert property (@(posedge smp_clk_i) disable iff (!lk_rst_n)
      !lk_s2_reg[2] |=> !pins_reg[0].ddr_output_clock_pos && pins_reg[0].ddr_lane == 6'h0)
      else $error("DDR pins active in parallel mode");

   // Checks, bus domain

   a_buf_tristate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ctrl_reg.pwr_mode == `DAFMT_MODE_BUF_A |=> !live_reg[0])
      else $error("channel A live while buffer disabled");
   a_buf_wake: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $fell(off[0]) && $past(cause[0]) == dafmt_pkg::DAFMT_CH_BUF_OFF
      |-> !live_reg[0] [*8] ##1 !live_reg[0] ##1 !live_reg[0] ##1 !live_reg[0] ##1 live_reg[0])
      else $error("buffer wake time wrong");
   a_stby_b: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ctrl_reg.pwr_mode == `DAFMT_MODE_STBY_B && !low_pwr_reg
      |=> chan_pd_o == 2'b10 && !ref_pd_o)
      else $error("standby B powers wrong blocks");
   a_low_rate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      idle_cnt_reg == LOWRATE_CYC && !smp_edge |=> low_power_o ##1 chan_pd_o == 2'b11)
      else $error("stopped clock did not force low power");
   a_avl_answer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer late");
endmodule // dafmt_top

// file: dafmt_rx_model.sv
/*
 Behavioural capture receiver for one channel's output pins.
 Assumes pins that change together on the link clock.
*/
`timescale 1ns/10ps

module dafmt_rx_model (
   // Pins from the converter
   input wire dafmt_pkg::dafmt_pins_s pins_i,
   // Captured words
   output logic [10:0] par_word_o,
   output logic [10:0] ddr_word_o,
   output int par_cnt_o,
   output int ddr_cnt_o
);
   logic [5:0] even_bits;

   initial begin
      par_word_o = 11'h000;
      ddr_word_o = 11'h000;
      par_cnt_o = 0;
      ddr_cnt_o = 0;
      even_bits = 6'h00;
   end

   always @(negedge pins_i.ddr_output_clock_pos) begin
      #4;
      even_bits = pins_i.ddr_lane;
   end

   always @(posedge pins_i.ddr_output_clock_pos) begin
      #4;
      for (int k = 0; k < 6; k++) begin
         ddr_word_o[2*k] = even_bits[k];
         if (k < 5) begin
            ddr_word_o[2*k+1] = pins_i.ddr_lane[k];
         end
      end
      ddr_cnt_o++;
   end

   // Rising edge capture
   // The bench runs far below the rate where a delayed clock is needed
   always @(posedge pins_i.parallel_output_clock) begin
      par_word_o <= pins_i.par_data;
      par_cnt_o <= par_cnt_o + 1;
   end
endmodule // dafmt_rx_model

// file: tb_dual_adc_output_formatter.sv
/*
 Self-checking bench of the dual converter output formatter.
 Assumes the design files and the capture model are compiled first.
*/
`timescale 1ns/10ps
`include "dafmt_regs.svh"

module tb_dual_adc_output_formatter;
   typedef struct packed {
      logic [6:0] ctrl;
      logic pin;
      logic [10:0] code;
      logic op;
      logic on;
      logic [10:0] exp;
   } dafmt_row_s;
   localparam dafmt_row_s ROWS [12] = '{
      '{7'h00, 1'h0, 11'h5a3, 1'h0, 1'h0, 11'h5a3},
      '{7'h20, 1'h0, 11'h5a3, 1'h0, 1'h0, 11'h1a3},
      '{7'h10, 1'h0, 11'h6c9, 1'h0, 1'h0, 11'h6c9},
      '{7'h30, 1'h0, 11'h6c9, 1'h0, 1'h0, 11'h2c9},
      '{7'h00, 1'h0, 11'h123, 1'h1, 1'h0, 11'h7ff},
      '{7'h20, 1'h0, 11'h123, 1'h1, 1'h0, 11'h3ff},
      '{7'h10, 1'h0, 11'h456, 1'h0, 1'h1, 11'h000},
      '{7'h30, 1'h0, 11'h456, 1'h0, 1'h1, 11'h400},
      '{7'h40, 1'h1, 11'h0f0, 1'h0, 1'h0, 11'h4f0},
      '{7'h40, 1'h0, 11'h0f0, 1'h0, 1'h0, 11'h0f0},
      '{7'h00, 1'h0, 11'h456, 1'h0, 1'h1, 11'h000},
      '{7'h20, 1'h0, 11'h456, 1'h0, 1'h1, 11'h400}};
   // Mode, oe A/B, power-down B/A, reference power-down
   localparam logic [8:0] PWR [8] = '{9'h018, 9'h130, 9'h148, 9'h160,
      9'h187, 9'h1b4, 9'h1ca, 9'h1f0};
   localparam int WK_MODE [2] = '{11, 14};
   localparam int WK_LO [2] = '{5, 50};
   localparam int WK_HI [2] = '{30, 125};

   logic clock_i, rst_n_i, smp_clk_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic smp_run = 1'b1;
   logic [3:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic format_select_pin_i, ref_pd_o, low_power_o, ddr, twos;
   logic [1:0] chan_pd_o;
   dafmt_pkg::dafmt_sample_s samp_a_i, samp_b_i;
   dafmt_pkg::dafmt_pins_s pins_a_o, pins_b_o;
   logic [10:0] par_a, ddr_a, par_b, ddr_b;
   int pca, dca, pcb, dcb, np, nd;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;

   dafmt_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .smp_clk_i(smp_clk_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .samp_a_i(samp_a_i), .samp_b_i(samp_b_i),
      .format_select_pin_i(format_select_pin_i), .chan_pd_o(chan_pd_o),
      .ref_pd_o(ref_pd_o), .low_power_o(low_power_o), .pins_a_o(pins_a_o),
      .pins_b_o(pins_b_o));
   dafmt_rx_model rx_a (.pins_i(pins_a_o), .par_word_o(par_a), .ddr_word_o(ddr_a),
      .par_cnt_o(pca), .ddr_cnt_o(dca));
   dafmt_rx_model rx_b (.pins_i(pins_b_o), .par_word_o(par_b), .ddr_word_o(ddr_b),
      .par_cnt_o(pcb), .ddr_cnt_o(dcb));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // Link clock stops only when the low-rate case asks for it
   initial begin
      smp_clk_i = 1'b0;
      #3;
      forever #16 smp_clk_i = ~smp_clk_i & smp_run;
   end

   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_address_i <= a;
      avs_writedata_i <= d;
      @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0) begin
         @(posedge clock_i);
      end
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   function automatic logic [10:0] fmt(input logic [10:0] c, input logic t);
      return t ? {~c[10], c[9:0]} : c;
   endfunction

   task automatic end_of_test();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      rst_n_i = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 4'h0;
      avs_writedata_i = 32'h0;
      samp_a_i = '0;
      samp_b_i = '0;
      format_select_pin_i = 1'b0;
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (20) @(posedge clock_i);
      bus(1'b0, `DAFMT_CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      bus(1'b1, 4'h8, 32'hffffffff);
      bus(1'b1, `DAFMT_STAT_OFS, 32'hffffffff);
      bus(1'b0, 4'h8, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, `DAFMT_STAT_OFS, 32'h0);
      chk("status", 32'h6, rd);
      foreach (ROWS[i]) begin
         format_select_pin_i <= ROWS[i].pin;
         bus(1'b1, `DAFMT_CTRL_OFS, {25'h0, ROWS[i].ctrl});
         @(posedge smp_clk_i);
         samp_a_i <= '{code: ROWS[i].code, ovr_pos: ROWS[i].op, ovr_neg: ROWS[i].on};
         samp_b_i <= '{code: ~ROWS[i].code, ovr_pos: ROWS[i].op, ovr_neg: ROWS[i].on};
         ddr = ROWS[i].ctrl[6] ? ROWS[i].pin : ROWS[i].ctrl[4];
         twos = ROWS[i].ctrl[6] ? ROWS[i].pin : ROWS[i].ctrl[5];
         repeat (10) @(posedge smp_clk_i);
         np = pca;
         nd = dca;
         repeat (4) @(posedge smp_clk_i);
         chk("word a", ROWS[i].exp, ddr ? ddr_a : par_a);
         chk("word b", (ROWS[i].op || ROWS[i].on) ? ROWS[i].exp : fmt(~ROWS[i].code, twos),
            ddr ? ddr_b : par_b);
         chk("par count", ddr ? 0 : 2, pca - np);
         chk("ddr count", ddr ? 2 : 0, dca - nd);
      end
      foreach (PWR[i]) begin
         bus(1'b1, `DAFMT_CTRL_OFS, {28'h0, PWR[i][8:5]});
         repeat (2100) @(posedge clock_i);
         @(negedge clock_i);
         chk("power oe", PWR[i][4:3], {pins_a_o.oe, pins_b_o.oe});
         chk("power pd", PWR[i][2:0], {chan_pd_o, ref_pd_o});
      end
      foreach (WK_MODE[i]) begin
         bus(1'b1, `DAFMT_CTRL_OFS, WK_MODE[i]);
         repeat (200) @(posedge clock_i);
         bus(1'b1, `DAFMT_CTRL_OFS, 32'h0);
         repeat (WK_LO[i]) @(negedge clock_i);
         chk("still off", 32'h0, pins_a_o.oe);
         repeat (WK_HI[i] - WK_LO[i]) @(negedge clock_i);
         chk("awake", 32'h1, pins_a_o.oe);
      end
      smp_run = 1'b0;
      repeat (150) @(posedge clock_i);
      @(negedge clock_i);
      chk("low power", 32'h1, low_power_o);
      chk("low power pd", 32'h3, chan_pd_o);
      bus(1'b0, `DAFMT_STAT_OFS, 32'h0);
      chk("low power status", 32'h19, rd);
      smp_run = 1'b1;
      repeat (300) @(posedge clock_i);
      @(negedge clock_i);
      chk("low power off", 32'h0, low_power_o);
      chk("live again", 32'h1, pins_a_o.oe);
      end_of_test();
   end
endmodule // tb_dual_adc_output_formatter
